// file: rtl/cdr_lock_detect_squelch.sv
// Lock detector, acquisition sweep, harmonic detector and squelch control
//
// Function
// (RULE_01) Lock to any rate without reference
// (RULE_02) Error above 1000 ppm asserts loss of lock
// (RULE_03) Acquisition restarts tune at range bottom
// (RULE_04) Coarse then fine steps; release within 250
// (RULE_05) Release hands over to phase tracking
// (RULE_06) Loss of lock shows hysteresis
// (RULE_07) Control A bit 0 selects reference mode
// (RULE_08) Host programs range and ratio first
// (RULE_09) Reference mode compares divided clocks
// (RULE_10) Sticky status bit 4 set on loss
// (RULE_11) Write 1 then 0 clears sticky bit
// (RULE_12) Control B bit 7 selects pin source
// (RULE_13) Lower harmonic forces reacquisition
// (RULE_14) Harmonic detection within 16384 transitions
// (RULE_15) Higher harmonic is ordinary loss of lock
// (RULE_16) Harmonic detector off in reference mode
// (RULE_17) Squelch mode 0 zeroes clock and data
// (RULE_18) Squelch mode 1 splits data and clock
// (RULE_19) Host never sets reference and readback together
// (RULE_20) Host retoggles reference enable after changes
// (RULE_21) Squelch synchronised; no runt clock pulses
`timescale 1ns/1ps
`default_nettype none
module cdr_lock_detect_squelch
    import cdr_ctrl_pkg::*;
#(
    parameter int HARM_EDGE_LIMIT = HARM_EDGES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] control_a_register,
    input wire logic [7:0] control_b_register,
    input wire logic [7:0] control_c_register,
    input wire logic [15:0] data_err_ppm,
    input wire logic data_osc_slow,
    input wire logic data_valid,
    input wire logic [15:0] ref_err_ppm,
    input wire logic ref_osc_slow,
    input wire logic bit_strobe,
    input wire logic rec_clk_in,
    input wire logic rec_data_in,
    input wire logic squelch_in,
    output logic [15:0] osc_tune,
    output logic fll_enable,
    output logic [1:0] ref_range,
    output logic [3:0] ref_ratio,
    output logic loss_of_lock_indicator,
    output logic [7:0] status_register,
    output logic recovered_clock_output,
    output logic recovered_data_output
);
    lock_state_e state_reg;
    logic lock_lost_reg;
    logic [15:0] osc_tune_reg;
    logic sticky_reg;
    logic clr_arm_reg;
    logic pin_reg;
    logic ref_mode_reg;
    logic [1:0] ref_range_reg;
    logic [3:0] ref_ratio_reg;
    logic prev_bit_reg;
    logic [1:0] run_len_reg;
    logic [14:0] harm_count_reg;
    logic harm_hit_reg;
    logic squelch_q;
    logic clk_kill_reg;
    logic clk_out_reg;
    logic data_out_reg;
    logic ref_mode;
    logic ref_start;
    logic [15:0] err_sel;
    logic osc_slow_sel;
    logic stream_ok;
    logic lose_lock;
    logic gain_lock;
    logic [16:0] tune_up;
    logic sticky_clear;
    logic data_kill;
    logic clk_kill_next;

    ////////////////////////////////////////////////////////////////////////////
    // Frequency comparison source
    ////////////////////////////////////////////////////////////////////////////

    assign ref_mode = control_a_register[CA_REF_EN]; // RULE_07
    assign ref_start = ref_mode && !ref_mode_reg;
    // Reference mode judges divided oscillator against divided reference
    assign err_sel = ref_mode ? ref_err_ppm : data_err_ppm; // RULE_09
    assign osc_slow_sel = ref_mode ? ref_osc_slow : data_osc_slow; // RULE_09
    // Without a reference, release waits for a live data stream
    assign stream_ok = ref_mode || data_valid; // RULE_01

    // A higher harmonic simply shows up as a large frequency error
    assign lose_lock = (err_sel > LOSS_ASSERT_PPM) || harm_hit_reg || ref_start; // RULE_02 RULE_15
    assign gain_lock = (err_sel <= LOSS_RELEASE_PPM) && stream_ok; // RULE_04 RULE_06

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ref_mode_reg <= 1'b0;
            ref_range_reg <= 2'h0;
            ref_ratio_reg <= 4'h0;
        end else begin
            ref_mode_reg <= ref_mode;
            ref_range_reg <= control_a_register[CA_RANGE_MSB:CA_RANGE_LSB];
            ref_ratio_reg <= control_a_register[CA_RATIO_MSB:CA_RATIO_LSB];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Acquisition state and loss of lock with hysteresis
    ////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= LOCK_ACQUIRE;
            lock_lost_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                LOCK_ACQUIRE: begin
                    if (ref_start) begin
                        lock_lost_reg <= 1'b1;
                    end else if (gain_lock) begin
                        state_reg <= LOCK_TRACK; // RULE_05
                        lock_lost_reg <= 1'b0; // RULE_04
                    end
                end
                LOCK_TRACK: begin
                    if (lose_lock) begin
                        state_reg <= LOCK_ACQUIRE; // RULE_02 RULE_13
                        lock_lost_reg <= 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Coarse oscillator sweep
    ////////////////////////////////////////////////////////////////////////////

    assign tune_up = {1'b0, osc_tune_reg} +
        {1'b0, (err_sel > COARSE_BAND_PPM) ? TUNE_STEP_LARGE : TUNE_STEP_SMALL};

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            osc_tune_reg <= TUNE_MIN;
        end else if ((state_reg == LOCK_TRACK && lose_lock) || ref_start) begin
            osc_tune_reg <= TUNE_MIN; // RULE_03
        end else if (state_reg == LOCK_ACQUIRE && !gain_lock) begin
            if (osc_slow_sel) begin
                // Saturate rather than wrap back to the bottom of the range
                osc_tune_reg <= tune_up[16] ? TUNE_MAX : tune_up[15:0]; // RULE_04
            end else if (osc_tune_reg != TUNE_MIN && err_sel > LOSS_RELEASE_PPM) begin
                osc_tune_reg <= osc_tune_reg - TUNE_STEP_SMALL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky status and indicator pin
    ////////////////////////////////////////////////////////////////////////////

    // Clear fires on the 1-to-0 step of the clear bit
    assign sticky_clear = clr_arm_reg && !control_b_register[CB_STICKY_CLR]; // RULE_11

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clr_arm_reg <= 1'b0;
            sticky_reg <= 1'b0;
        end else begin
            clr_arm_reg <= control_b_register[CB_STICKY_CLR];
            // A loss of lock in the clearing cycle still sets the bit
            if (lock_lost_reg) begin
                sticky_reg <= 1'b1; // RULE_10
            end else if (sticky_clear) begin
                sticky_reg <= 1'b0; // RULE_11
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_reg <= 1'b1;
        end else begin
            pin_reg <= control_b_register[CB_PIN_STATIC] ? sticky_reg : lock_lost_reg; // RULE_12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Lower harmonic detector
    ////////////////////////////////////////////////////////////////////////////

    // A true-rate stream keeps showing one-bit runs; a lower harmonic never does
    always_ff @(posedge clk_sys) begin
        if (sys_rst || ref_mode || state_reg == LOCK_ACQUIRE) begin
            prev_bit_reg <= 1'b0;
            run_len_reg <= 2'h0;
            harm_count_reg <= 15'h0000; // RULE_16
            harm_hit_reg <= 1'b0;
        end else begin
            harm_hit_reg <= 1'b0;
            if (bit_strobe) begin
                prev_bit_reg <= rec_data_in;
                if (rec_data_in != prev_bit_reg) begin
                    run_len_reg <= 2'h1;
                    if (run_len_reg == 2'h1) begin
                        harm_count_reg <= 15'h0000;
                    end else if (harm_count_reg == 15'(HARM_EDGE_LIMIT - 1)) begin
                        harm_count_reg <= 15'h0000;
                        harm_hit_reg <= 1'b1; // RULE_13 RULE_14
                    end else begin
                        harm_count_reg <= harm_count_reg + 15'h0001;
                    end
                end else if (run_len_reg != 2'h3) begin
                    run_len_reg <= run_len_reg + 2'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Squelch of recovered clock and data
    ////////////////////////////////////////////////////////////////////////////

    level_sync u_squelch_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(squelch_in),
        .sync_out(squelch_q)
    ); // RULE_21

    assign data_kill = squelch_q; // RULE_17 RULE_18
    assign clk_kill_next = control_c_register[CC_SQ_OR] ? !squelch_q : squelch_q; // RULE_18

    // Clock gate only moves while the clock is low, so no pulse is ever cut short
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clk_kill_reg <= 1'b1;
        end else if (!rec_clk_in) begin
            clk_kill_reg <= clk_kill_next; // RULE_21
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            clk_out_reg <= 1'b0;
            data_out_reg <= 1'b0;
        end else begin
            clk_out_reg <= rec_clk_in && !clk_kill_reg; // RULE_17
            data_out_reg <= rec_data_in && !data_kill; // RULE_17
        end
    end

    assign osc_tune = osc_tune_reg;
    assign fll_enable = lock_lost_reg; // RULE_05
    assign ref_range = ref_range_reg; // RULE_08
    assign ref_ratio = ref_ratio_reg; // RULE_08
    assign loss_of_lock_indicator = pin_reg;
    assign status_register = STATUS_RESET | (8'(sticky_reg) << ST_STICKY_LOSS);
    assign recovered_clock_output = clk_out_reg;
    assign recovered_data_output = data_out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////////

    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    sequence s_locked_big_err;
        state_reg == LOCK_TRACK && err_sel > LOSS_ASSERT_PPM;
    endsequence

    sequence s_squelch_steady;
        squelch_q [*2];
    endsequence

    a_loss_on_error: assert property (s_locked_big_err |=> // RULE_02
        lock_lost_reg && osc_tune_reg == TUNE_MIN)
        else $error("loss of lock not raised above assert threshold");
    a_sweep_restart: assert property ($rose(lock_lost_reg) |-> osc_tune_reg == TUNE_MIN) // RULE_03
        else $error("acquisition did not start at tune bottom");
    a_release_band: assert property ($fell(lock_lost_reg) |-> // RULE_04
        $past(err_sel) <= LOSS_RELEASE_PPM)
        else $error("loss of lock released outside release band");
    a_loss_hysteresis: assert property (lock_lost_reg && err_sel > LOSS_RELEASE_PPM |=> // RULE_06
        lock_lost_reg)
        else $error("loss of lock dropped inside hysteresis band");
    a_fll_handoff: assert property (!lock_lost_reg && !$past(lock_lost_reg) |-> // RULE_05
        $stable(osc_tune_reg))
        else $error("coarse tune moved while tracking");
    a_sticky_set: assert property (lock_lost_reg |=> status_register[ST_STICKY_LOSS]) // RULE_10
        else $error("sticky bit not set on loss of lock");
    a_sticky_hold: assert property (sticky_reg && !sticky_clear |=> sticky_reg) // RULE_11
        else $error("sticky bit cleared without clear sequence");
    a_pin_source: assert property (##1 loss_of_lock_indicator == // RULE_12
        ($past(control_b_register[CB_PIN_STATIC]) ? $past(sticky_reg) : $past(lock_lost_reg)))
        else $error("indicator pin shows wrong source");
    // The release may follow at once, since only the error input and data_valid decide relock
    a_harm_relock: assert property (harm_hit_reg |=> // RULE_13
        lock_lost_reg && osc_tune_reg == TUNE_MIN)
        else $error("harmonic hit did not force acquisition");
    a_harm_ref_off: assert property ($past(ref_mode) |-> harm_count_reg == 15'h0000 && !harm_hit_reg) // RULE_16
        else $error("harmonic detector active in reference mode");
    a_squelch_and: assert property (s_squelch_steady ##0 !control_c_register[CC_SQ_OR]
        |=> !recovered_data_output) // RULE_17
        else $error("data not squelched in mode zero");
    a_clk_gate: assert property (clk_kill_reg |=> !recovered_clock_output) // RULE_18
        else $error("clock not squelched while gate closed");
    a_no_runt: assert property ($changed(clk_kill_reg) |-> !$past(rec_clk_in)) // RULE_21
        else $error("clock gate changed while clock high");
endmodule : cdr_lock_detect_squelch
`default_nettype wire

// file: rtl/cdr_ctrl_pkg.sv
// Shared constants for the recovered-clock lock, harmonic and squelch control
package cdr_ctrl_pkg;
    // Lock detector thresholds, in ppm of frequency error
    localparam logic [15:0] LOSS_ASSERT_PPM = 16'h03E8;
    localparam logic [15:0] LOSS_RELEASE_PPM = 16'h00FA;
    // Above this error the sweep uses the coarse step
    localparam logic [15:0] COARSE_BAND_PPM = 16'h0FA0;
    // Coarse oscillator tune code: bottom is the lowest rate of the range
    localparam logic [15:0] TUNE_MIN = 16'h0000;
    localparam logic [15:0] TUNE_MAX = 16'hFFFF;
    localparam logic [15:0] TUNE_STEP_LARGE = 16'h0100;
    localparam logic [15:0] TUNE_STEP_SMALL = 16'h0001;
    // Transitions without a one-bit run before a lower harmonic is declared
    localparam int HARM_EDGES = 16384;
    // Control A field positions
    localparam int CA_REF_EN = 0;
    localparam int CA_FINE_RB = 1;
    localparam int CA_RATIO_LSB = 2;
    localparam int CA_RATIO_MSB = 5;
    localparam int CA_RANGE_LSB = 6;
    localparam int CA_RANGE_MSB = 7;
    // Control B and C field positions
    localparam int CB_STICKY_CLR = 6;
    localparam int CB_PIN_STATIC = 7;
    localparam int CC_SQ_OR = 1;
    // Status field position
    localparam int ST_STICKY_LOSS = 4;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam int SYNC_STAGES = 2;
    typedef enum logic {LOCK_ACQUIRE, LOCK_TRACK} lock_state_e;
endpackage : cdr_ctrl_pkg

// file: rtl/level_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module level_sync (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_reg;
    logic sync_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule : level_sync
`default_nettype wire

// file: sim/serial_line_model.sv
// Serial line model: recovered clock, bit strobe and data at full rate or a lower harmonic
`timescale 1ns/1ps
`default_nettype none
module serial_line_model (
    input wire logic clk_sys,
    input wire logic harm_mode,
    output logic rec_clk_in,
    output logic rec_data_in,
    output logic bit_strobe
);
    logic [1:0] phase_reg = 2'h0;
    logic [1:0] run_reg = 2'h0;
    initial begin
        rec_clk_in = 1'b0;
        rec_data_in = 1'b0;
        bit_strobe = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Driven on the falling edge so the block samples settled levels
    always @(negedge clk_sys) begin
        phase_reg <= phase_reg + 2'h1;
        rec_clk_in <= phase_reg[1];
        bit_strobe <= (phase_reg == 2'h1);
        if (phase_reg == 2'h1) begin
            run_reg <= run_reg + 2'h1;
            // A harmonic stream stretches every run to four bits, never one
            if (!harm_mode || run_reg == 2'h3) begin
                rec_data_in <= !rec_data_in;
            end
        end
    end
endmodule : serial_line_model
`default_nettype wire

// file: sim/cdr_lock_detect_squelch_test.sv
// Self-checking bench for the lock detector, sticky status, harmonic detector and squelch
`timescale 1ns/1ps
`default_nettype none
module cdr_lock_detect_squelch_test;
    import cdr_ctrl_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] ctl_a = 8'h00;
    logic [7:0] ctl_b = 8'h00;
    logic [7:0] ctl_c = 8'h00;
    logic [15:0] data_err = 16'h0000;
    logic [15:0] ref_err = 16'h0000;
    logic data_slow = 1'b0;
    logic ref_slow = 1'b1;
    logic data_valid = 1'b0;
    logic squelch_in = 1'b0;
    logic harm_mode = 1'b0;
    logic rec_clk_in, rec_data_in, bit_strobe, fll_enable, loss_pin, clk_out, data_out;
    logic [15:0] osc_tune;
    logic [15:0] v;
    logic [1:0] ref_range;
    logic [3:0] ref_ratio;
    logic [7:0] status_register;
    int err_total = 0;
    int num_checks = 0;
    int cycles = 0;
    integer seed = 32'h8e92;
    always #12.5 clk_sys = !clk_sys;
    serial_line_model serial_line_model_inst (.clk_sys(clk_sys), .harm_mode(harm_mode),
        .rec_clk_in(rec_clk_in), .rec_data_in(rec_data_in), .bit_strobe(bit_strobe));
    cdr_lock_detect_squelch #(.HARM_EDGE_LIMIT(16)) cdr_lock_detect_squelch_inst (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .control_a_register(ctl_a),
        .control_b_register(ctl_b), .control_c_register(ctl_c), .data_err_ppm(data_err),
        .data_osc_slow(data_slow), .data_valid(data_valid), .ref_err_ppm(ref_err),
        .ref_osc_slow(ref_slow), .bit_strobe(bit_strobe), .rec_clk_in(rec_clk_in),
        .rec_data_in(rec_data_in), .squelch_in(squelch_in), .osc_tune(osc_tune),
        .fll_enable(fll_enable), .ref_range(ref_range), .ref_ratio(ref_ratio),
        .loss_of_lock_indicator(loss_pin), .status_register(status_register),
        .recovered_clock_output(clk_out), .recovered_data_output(data_out));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Checks %0d, errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    // Error 1 to 2000 ppm over the assert threshold, drawn at random
    function automatic logic [15:0] big_err();
        return 16'd1001 + 16'($unsigned($random(seed)) % 2000);
    endfunction : big_err
    task automatic lose();
        data_err = big_err();
        cyc(1);
        chk("tune after loss", 16'h0000, osc_tune);
        chk("fll after loss", 1, fll_enable);
        // The pin lags one edge more when it mirrors the sticky bit
        cyc(2);
        chk("pin after loss", 1, loss_pin);
        chk("sticky set", 1, status_register[ST_STICKY_LOSS]);
        data_err = 16'd250;
        cyc(3);
    endtask : lose
    // Squelch mode, squelch level, then whether clock and data still toggle
    task automatic sq_case(input logic mode, input logic sq, input logic ck, input logic dt);
        logic seen_ck;
        logic seen_dt;
        seen_ck = 1'b0;
        seen_dt = 1'b0;
        ctl_c[CC_SQ_OR] = mode;
        squelch_in = sq;
        cyc(10);
        repeat (16) begin
            cyc(1);
            seen_ck |= clk_out;
            seen_dt |= data_out;
        end
        chk("clock activity", ck, seen_ck);
        chk("data activity", dt, seen_dt);
    endtask : sq_case
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 20000) begin
            err_total++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        cyc(12);
        sys_rst = 1'b0;
        cyc(1);
        chk("tune at reset", TUNE_MIN, osc_tune);
        chk("pin at reset", 1, loss_pin);
        data_err = 16'd5000;
        data_slow = 1'b1;
        cyc(4);
        chk("coarse low byte", 16'h0000, osc_tune[7:0]);
        chk("coarse moved", 1, osc_tune >= 16'h0300);
        data_err = 16'd2000;
        cyc(3);
        chk("fine steps", 16'h0003, osc_tune[7:0]);
        data_slow = 1'b0;
        cyc(2);
        chk("overshoot step down", 16'h0001, osc_tune[7:0]);
        data_slow = 1'b1;
        data_valid = 1'b1;
        data_err = 16'd251 + 16'($unsigned($random(seed)) % 750);
        cyc(5);
        chk("no release above 250", 1, loss_pin);
        data_err = 16'd250;
        cyc(3);
        chk("release at 250", 0, loss_pin);
        chk("fll off", 0, fll_enable);
        v = osc_tune;
        data_err = 16'd1000;
        cyc(5);
        chk("tune frozen", v, osc_tune);
        chk("hold at 1000", 0, loss_pin);
        lose();
        chk("sticky after relock", 1, status_register[ST_STICKY_LOSS]);
        ctl_b[CB_STICKY_CLR] = 1'b1;
        cyc(1);
        ctl_b[CB_STICKY_CLR] = 1'b0;
        cyc(2);
        chk("status cleared", STATUS_RESET, status_register);
        ctl_b[CB_PIN_STATIC] = 1'b1;
        cyc(5);
        chk("static pin low", 0, loss_pin);
        lose();
        chk("static pin held", 1, loss_pin);
        ctl_b = 8'h00;
        cyc(2);
        chk("live pin", 0, loss_pin);
        cyc(400);
        chk("no false harmonic", 0, loss_pin);
        harm_mode = 1'b1;
        for (int i = 0; i < 400 && loss_pin !== 1'b1; i++) cyc(1);
        chk("harmonic found", 1, loss_pin);
        harm_mode = 1'b0;
        cyc(3);
        chk("harmonic relock", 0, loss_pin);
        ctl_a = {8'($random(seed)) & 8'hFC};
        cyc(1);
        ctl_a[CA_REF_EN] = 1'b1;
        data_err = 16'd5000;
        ref_err = 16'd100;
        cyc(3);
        chk("ref release", 0, loss_pin);
        chk("ref range", ctl_a[7:6], ref_range);
        chk("ref ratio", ctl_a[5:2], ref_ratio);
        harm_mode = 1'b1;
        cyc(400);
        chk("harmonic off in ref", 0, loss_pin);
        harm_mode = 1'b0;
        ref_err = big_err();
        cyc(2);
        chk("ref loss", 1, loss_pin);
        ref_err = 16'd100;
        cyc(3);
        chk("ref relock", 0, loss_pin);
        sq_case(1'b0, 1'b0, 1'b1, 1'b1);
        sq_case(1'b0, 1'b1, 1'b0, 1'b0);
        sq_case(1'b1, 1'b1, 1'b1, 1'b0);
        sq_case(1'b1, 1'b0, 1'b0, 1'b1);
        stop_test();
    end
endmodule : cdr_lock_detect_squelch_test
`default_nettype wire
